// ===== hw/gpt_timer.sv
// Timer block top: 32-bit timer, RTC and two split 16-bit halves
`timescale 1ns/100ps
`default_nettype none
module gpt_timer (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [2:0] timer_config, // Configuration value
  input wire logic [1:0] first_half_mode_field, // First half mode
  input wire logic [1:0] second_half_mode_field, // Second half mode
  input wire logic capture_mode_select_a, // First half capture mode
  input wire logic capture_mode_select_b, // Second half capture mode
  input wire logic [1:0] edge_type_select_a, // First half edge select
  input wire logic [1:0] edge_type_select_b, // Second half edge select
  input wire logic en_wr_a, // Write strobe, first enable
  input wire logic en_wdata_a, // Value for first enable
  input wire logic en_wr_b, // Write strobe, second enable
  input wire logic en_wdata_b, // Value for second enable
  input wire logic ild_wr_a, // Write first interval load
  input wire logic ild_wr_b, // Write second interval load
  input wire logic ild_wr32, // Write joined interval load
  input wire logic [31:0] ild_wdata, // Interval load write data
  input wire logic [7:0] prescale_a, // First half prescale
  input wire logic [7:0] prescale_b, // Second half prescale
  input wire logic [15:0] match_a, // First half match
  input wire logic [15:0] match_b, // Second half match
  input wire logic first_half_stall, // Stall first half
  input wire logic second_half_stall, // Stall second half
  input wire logic rtc_stall_override, // RTC ignores stall
  input wire logic first_trigger_enable, // First trigger enable
  input wire logic second_trigger_enable, // Second trigger enable
  input wire logic [4:0] irq_mask, // Interrupt mask
  input wire logic [4:0] irq_clear, // Flag clear pulses
  input wire logic capture_compare_pin_a, // Capture pin A, RTC clock
  input wire logic capture_compare_pin_b, // Capture pin B
  output logic first_half_enable, // First enable state
  output logic second_half_enable, // Second enable state
  output logic [15:0] count_a, // Low counter half
  output logic [15:0] count_b, // High counter half
  output logic [4:0] raw_irq_status, // Sticky raw flags
  output logic [4:0] masked_irq_status, // Masked flags
  output logic trigger_a, // First trigger pulse
  output logic trigger_b, // Second trigger pulse
  output logic rtc_irq // RTC interrupt
);
  logic [15:0] ild_a_q;
  logic [15:0] ild_b_q;
  logic [31:0] ild32;
  logic [31:0] match32;
  logic [31:0] cnt32_q;
  logic [14:0] div_q;
  logic ld_a_q;
  logic ld_b_q;
  logic was_rtc_q;
  logic rise_a;
  logic fall_a;
  logic rise_b;
  logic fall_b;
  logic split;
  logic tmode32;
  logic run32;
  logic to32;
  logic rtc_mode;
  logic rtc_enter;
  logic tick;
  logic rtc_step;
  logic rtc_hit;
  logic [15:0] hcnt_a;
  logic [15:0] hcnt_b;
  logic to_a;
  logic to_b;
  logic cm_a;
  logic cm_b;
  logic stop_a;
  logic stop_b;
  logic [4:0] set_v;
  logic [4:0] raw_d;

  gpt_pin_sync u_sync_a (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(capture_compare_pin_a),
    .rise(rise_a),
    .fall(fall_a)
  );

  gpt_pin_sync u_sync_b (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin(capture_compare_pin_b),
    .rise(rise_b),
    .fall(fall_b)
  );

  assign split = timer_config == gpt_pkg::CFG_SPLIT;
  assign rtc_mode = timer_config == gpt_pkg::CFG_32_RTC;
  assign ild32 = {ild_b_q, ild_a_q};
  assign match32 = {match_b, match_a};

  gpt_half u_half_a (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .active(split),
    .en(first_half_enable),
    .mode(first_half_mode_field),
    .cmr(capture_mode_select_a),
    .evsel(edge_type_select_a),
    .stall(first_half_stall),
    .ild(ild_a_q),
    .psc(prescale_a),
    .match(match_a),
    .load(ld_a_q),
    .rise(rise_a),
    .fall(fall_a),
    .cnt_q(hcnt_a),
    .to_pls(to_a),
    .cm_pls(cm_a),
    .stop_pls(stop_a)
  );

  gpt_half u_half_b (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .active(split),
    .en(second_half_enable),
    .mode(second_half_mode_field),
    .cmr(capture_mode_select_b),
    .evsel(edge_type_select_b),
    .stall(second_half_stall),
    .ild(ild_b_q),
    .psc(prescale_b),
    .match(match_b),
    .load(ld_b_q),
    .rise(rise_b),
    .fall(fall_b),
    .cnt_q(hcnt_b),
    .to_pls(to_b),
    .cm_pls(cm_b),
    .stop_pls(stop_b)
  );

  always_comb begin
    tmode32 = timer_config == gpt_pkg::CFG_32_TIMER &&
              (first_half_mode_field == gpt_pkg::MODE_ONE_SHOT ||
               first_half_mode_field == gpt_pkg::MODE_PERIODIC);
    run32 = tmode32 && first_half_enable && !first_half_stall;
    to32 = run32 && cnt32_q == 32'h0000_0000;
    rtc_enter = rtc_mode && !was_rtc_q;
    tick = rtc_mode && first_half_enable && rise_a && div_q == gpt_pkg::RTC_DIV_LAST;
    rtc_step = tick && (!(first_half_stall || second_half_stall) || rtc_stall_override);
    rtc_hit = rtc_step && cnt32_q == match32;
  end

  // Interval loads; a write is applied to the counter one cycle later
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ild_a_q <= gpt_pkg::ILD_RST;
      ild_b_q <= gpt_pkg::ILD_RST;
      ld_a_q <= 1'b0;
      ld_b_q <= 1'b0;
    end else begin
      if (ild_wr32 || ild_wr_a) begin
        ild_a_q <= ild_wdata[15:0];
      end
      if (ild_wr32) begin
        ild_b_q <= ild_wdata[31:16];
      end else if (ild_wr_b) begin
        ild_b_q <= ild_wdata[15:0];
      end
      ld_a_q <= ild_wr32 || ild_wr_a;
      ld_b_q <= ild_wr32 || ild_wr_b;
    end
  end

  // Divides pin edges down to a one-second tick
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 15'h0000;
    end else if (!rtc_mode || !first_half_enable) begin
      div_q <= 15'h0000;
    end else if (rise_a) begin
      div_q <= (div_q == gpt_pkg::RTC_DIV_LAST) ? 15'h0000 : 15'(div_q + 15'h0001);
    end
  end

  // Joined 32-bit counter, down for the timer, up for the RTC
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt32_q <= {gpt_pkg::CNT_RST, gpt_pkg::CNT_RST};
      was_rtc_q <= 1'b0;
    end else begin
      was_rtc_q <= rtc_mode;
      if (rtc_enter) begin
        cnt32_q <= gpt_pkg::RTC_FIRST;
      end else if (tmode32 && (ld_a_q || to32)) begin
        cnt32_q <= ild32;
      end else if (run32) begin
        cnt32_q <= 32'(cnt32_q - 32'h0000_0001);
      end else if (rtc_hit) begin
        cnt32_q <= gpt_pkg::RTC_ROLL;
      end else if (rtc_step) begin
        cnt32_q <= 32'(cnt32_q + 32'h0000_0001);
      end
    end
  end

  // Software write wins over a hardware stop in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_half_enable <= 1'b0;
      second_half_enable <= 1'b0;
    end else begin
      if (en_wr_a) begin
        first_half_enable <= en_wdata_a;
      end else if (split ? stop_a : (to32 && first_half_mode_field == gpt_pkg::MODE_ONE_SHOT)) begin
        first_half_enable <= 1'b0;
      end
      if (en_wr_b) begin
        second_half_enable <= en_wdata_b;
      end else if (split && stop_b) begin
        second_half_enable <= 1'b0;
      end
    end
  end

  always_comb begin
    set_v = '0;
    set_v[gpt_pkg::FLG_TO_A] = split ? to_a : to32;
    set_v[gpt_pkg::FLG_CM_A] = cm_a;
    set_v[gpt_pkg::FLG_TO_B] = to_b;
    set_v[gpt_pkg::FLG_CM_B] = cm_b;
    set_v[gpt_pkg::FLG_RTC] = rtc_hit;
    raw_d = (raw_irq_status & ~irq_clear) | set_v;
  end

  // Flags, triggers and count views; all outputs leave from flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_irq_status <= '0;
      masked_irq_status <= '0;
      rtc_irq <= 1'b0;
      trigger_a <= 1'b0;
      trigger_b <= 1'b0;
      count_a <= gpt_pkg::CNT_RST;
      count_b <= gpt_pkg::CNT_RST;
    end else begin
      raw_irq_status <= raw_d;
      masked_irq_status <= raw_d & irq_mask;
      rtc_irq <= raw_d[gpt_pkg::FLG_RTC] & irq_mask[gpt_pkg::FLG_RTC];
      trigger_a <= set_v[gpt_pkg::FLG_TO_A] & first_trigger_enable;
      trigger_b <= to_b & second_trigger_enable;
      count_a <= split ? hcnt_a : cnt32_q[15:0];
      count_b <= split ? hcnt_b : cnt32_q[31:16];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_oneshot_stop: assert property (to32
    && first_half_mode_field == gpt_pkg::MODE_ONE_SHOT && !en_wr_a |=> !first_half_enable)
    else $error("one-shot did not stop");
  a_reload_joined: assert property (to32 && !ld_a_q && !rtc_enter
    |=> cnt32_q == $past(ild32)) else $error("32-bit reload wrong");
  a_timeout_flag: assert property (to32 |=> raw_irq_status[gpt_pkg::FLG_TO_A]
    ##1 raw_irq_status[gpt_pkg::FLG_TO_A] || $past(irq_clear[gpt_pkg::FLG_TO_A]))
    else $error("time-out flag not held");
  a_trigger_pulse: assert property (to32 && first_trigger_enable
    |=> trigger_a ##1 !trigger_a) else $error("trigger not one cycle");
  a_load_next: assert property (ld_a_q && tmode32 && !rtc_enter
    |=> cnt32_q == $past(ild32)) else $error("interval write not loaded");
  a_stall_hold: assert property (tmode32 && first_half_stall && !ld_a_q && !rtc_enter
    |=> $stable(cnt32_q)) else $error("stalled counter moved");
  a_rtc_first: assert property (rtc_enter |=> cnt32_q == gpt_pkg::RTC_FIRST)
    else $error("RTC entry not one");
  a_rtc_roll: assert property (rtc_hit |=> cnt32_q == gpt_pkg::RTC_ROLL
    && raw_irq_status[gpt_pkg::FLG_RTC]) else $error("RTC match failed");
  // Watches the raw tick, so a stall that swallowed it would show here
  a_rtc_override: assert property (tick && rtc_stall_override && !rtc_enter
    |=> cnt32_q == ($past(cnt32_q == match32) ? gpt_pkg::RTC_ROLL
    : 32'($past(cnt32_q) + 32'h0000_0001))) else $error("RTC tick lost under stall");
  a_edge_match: assert property (split && cm_b && !en_wr_b
    |=> !second_half_enable && raw_irq_status[gpt_pkg::FLG_CM_B])
    else $error("edge match failed");

  c_oneshot: cover property (to32 && first_half_mode_field == gpt_pkg::MODE_ONE_SHOT);
  c_rtc_match: cover property (rtc_hit);
  c_edge_match: cover property (cm_b);
  c_half_timeout: cover property (to_b ##1 trigger_b);
endmodule : gpt_timer
`default_nettype wire

// ===== hw/gpt_pkg.sv
// Shared constants for the general-purpose timer block
package gpt_pkg;
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_32_RTC = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_EDGE_COUNT = 2'h3;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;
  localparam logic [15:0] CNT_RST = 16'hFFFF;
  localparam logic [15:0] ILD_RST = 16'hFFFF;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
  localparam logic [31:0] RTC_ROLL = 32'h0000_0000;
  localparam int RTC_PIN_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_PIN_HZ / RTC_TICK_HZ - 1);
  localparam int NFLAG = 5;
  localparam int FLG_TO_A = 0;
  localparam int FLG_CM_A = 1;
  localparam int FLG_TO_B = 2;
  localparam int FLG_CM_B = 3;
  localparam int FLG_RTC = 4;

  // Edge selection shared by both halves
  function automatic logic ev_hit(input logic [1:0] sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EV_RISE: hit = rise;
      EV_FALL: hit = fall;
      EV_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : ev_hit
endpackage : gpt_pkg

// ===== hw/gpt_pin_sync.sv
// Capture pin synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
`default_nettype none
module gpt_pin_sync (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic pin, // Asynchronous capture pin
  output logic rise, // One-cycle rising edge pulse
  output logic fall // One-cycle falling edge pulse
);
  logic [2:0] sh_q;
  logic lvl_q;
  logic agree;

  // A level counts only once stages two and three agree
  assign agree = sh_q[1] == sh_q[2];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_q <= 3'h0;
      lvl_q <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      sh_q <= {sh_q[1:0], pin};
      if (agree) begin
        lvl_q <= sh_q[2];
      end
      rise <= agree && sh_q[2] && !lvl_q;
      fall <= agree && !sh_q[2] && lvl_q;
    end
  end
endmodule : gpt_pin_sync
`default_nettype wire

// ===== hw/gpt_half.sv
// One 16-bit half: prescaled down-counter or input edge counter
`timescale 1ns/100ps
`default_nettype none
module gpt_half (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic active, // Split 16-bit configuration selected
  input wire logic en, // Half enable
  input wire logic [1:0] mode, // Half mode field
  input wire logic cmr, // Capture mode select
  input wire logic [1:0] evsel, // Edge type select
  input wire logic stall, // Stall request
  input wire logic [15:0] ild, // Interval load value
  input wire logic [7:0] psc, // Prescale value
  input wire logic [15:0] match, // Match value
  input wire logic load, // Interval load was written
  input wire logic rise, // Synchronised rising edge
  input wire logic fall, // Synchronised falling edge
  output logic [15:0] cnt_q, // Counter value
  output logic to_pls, // Time-out this cycle
  output logic cm_pls, // Edge-count match this cycle
  output logic stop_pls // Hardware clears the enable
);
  logic [7:0] pcnt_q;
  logic run;
  logic edge_on;

  always_comb begin
    run = active && en && !stall &&
          (mode == gpt_pkg::MODE_ONE_SHOT || mode == gpt_pkg::MODE_PERIODIC);
    edge_on = active && en && !cmr && mode == gpt_pkg::MODE_EDGE_COUNT &&
              gpt_pkg::ev_hit(evsel, rise, fall);
    // The reload is a prescaled step too, so a period is (load+1)*(prescale+1) clocks
    to_pls = run && cnt_q == 16'h0000 && pcnt_q == 8'h00;
    cm_pls = edge_on && 16'(cnt_q - 16'h0001) == match;
    stop_pls = (to_pls && mode == gpt_pkg::MODE_ONE_SHOT) || cm_pls;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= gpt_pkg::CNT_RST;
    end else if (load || to_pls || cm_pls) begin
      cnt_q <= ild;
    end else if (edge_on) begin
      cnt_q <= 16'(cnt_q - 16'h0001);
    end else if (run && pcnt_q == 8'h00) begin
      cnt_q <= 16'(cnt_q - 16'h0001);
    end
  end

  // Prescaler: one step every psc+1 clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcnt_q <= gpt_pkg::PSC_RST;
    end else if (load || to_pls) begin
      pcnt_q <= psc;
    end else if (run) begin
      pcnt_q <= (pcnt_q == 8'h00) ? psc : 8'(pcnt_q - 8'h01);
    end
  end
endmodule : gpt_half
`default_nettype wire

// ===== sim/gpt_pin_model.sv
// Capture pin model: edge bursts on pin B, fast clock bursts on pin A
`timescale 1ns/100ps
`default_nettype none
module gpt_pin_model (
  input wire logic sys_clk, // System clock
  output logic pin_a, // Capture pin A, RTC clock
  output logic pin_b // Capture pin B
);
  initial begin
    pin_a = 1'h0;
    pin_b = 1'h0;
  end
  // The pin clock stands still between bursts, so the RTC only moves when asked;
  // each level stands two clocks since the synchroniser drops one-clock pulses
  task automatic run_a(input int n);
    repeat (n) begin
      @(negedge sys_clk) pin_a = 1'h1;
      @(negedge sys_clk);
      @(negedge sys_clk) pin_a = 1'h0;
      @(negedge sys_clk);
    end
  endtask : run_a
  // Levels held three cycles so that no edge is lost in the synchroniser
  task automatic pulse_b(input int n);
    repeat (n) begin
      repeat (3) @(negedge sys_clk);
      pin_b = 1'h1;
      repeat (3) @(negedge sys_clk);
      pin_b = 1'h0;
    end
  endtask : pulse_b
endmodule : gpt_pin_model
`default_nettype wire

// ===== sim/gpt_timer_tb_top.sv
// Self-checking bench for the timer block
`timescale 1ns/100ps
`default_nettype none
module gpt_timer_tb_top;
  typedef struct packed {
    logic [4:0] rise;
    logic [4:0] mskd;
    logic [1:0] ena;
    logic [1:0] trg;
    int exp;
    int gap;
  } gpt_note_t;
  logic sys_clk = 1'h0, arst_n = 1'h0;
  logic [2:0] cfg = 3'h0;
  logic [1:0] mode_a = 2'h0, mode_b = 2'h0, evsel_b = 2'h0;
  logic en_wr_a = 1'h0, en_d_a = 1'h0, en_wr_b = 1'h0, en_d_b = 1'h0;
  logic ild_wr_a = 1'h0, ild_wr_b = 1'h0, ild_wr32 = 1'h0;
  logic [31:0] ild_d = 32'h0, ld = 32'h0, rnd = 32'h8194909A;
  logic [7:0] psc_a = 8'h00, psc_b = 8'h00;
  logic [15:0] mt_a = 16'h0000, mt_b = 16'h0000;
  logic stl_a = 1'h0, stl_b = 1'h0, ovr = 1'h0, tr_a = 1'h0, tr_b = 1'h0;
  logic [4:0] msk = 5'h00, clr = 5'h00, prev = 5'h00;
  logic en_a, en_b, trg_a, trg_b, rtc_irq, pin_a, pin_b, tpend;
  logic [15:0] cnt_a, cnt_b;
  logic [4:0] raw, mskd;
  logic [1:0] sels [3] = '{gpt_pkg::EV_RISE, gpt_pkg::EV_FALL, gpt_pkg::EV_BOTH};
  int n_mismatch = 0, cmp_count = 0, cyc = 0, last = 0;
  gpt_note_t notes [$];
  gpt_note_t nt;

  gpt_timer u_gpt_timer (
    .sys_clk(sys_clk), .arst_n(arst_n), .timer_config(cfg),
    .first_half_mode_field(mode_a), .second_half_mode_field(mode_b),
    .capture_mode_select_a(1'h0), .capture_mode_select_b(1'h0),
    .edge_type_select_a(2'h0), .edge_type_select_b(evsel_b),
    .en_wr_a(en_wr_a), .en_wdata_a(en_d_a), .en_wr_b(en_wr_b), .en_wdata_b(en_d_b),
    .ild_wr_a(ild_wr_a), .ild_wr_b(ild_wr_b), .ild_wr32(ild_wr32), .ild_wdata(ild_d),
    .prescale_a(psc_a), .prescale_b(psc_b), .match_a(mt_a), .match_b(mt_b),
    .first_half_stall(stl_a), .second_half_stall(stl_b), .rtc_stall_override(ovr),
    .first_trigger_enable(tr_a), .second_trigger_enable(tr_b),
    .irq_mask(msk), .irq_clear(clr),
    .capture_compare_pin_a(pin_a), .capture_compare_pin_b(pin_b),
    .first_half_enable(en_a), .second_half_enable(en_b), .count_a(cnt_a), .count_b(cnt_b),
    .raw_irq_status(raw), .masked_irq_status(mskd), .trigger_a(trg_a), .trigger_b(trg_b),
    .rtc_irq(rtc_irq)
  );
  gpt_pin_model u_gpt_pin_model (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic note(input logic [4:0] r, input logic [4:0] m, input logic [1:0] e,
                      input logic [1:0] t, input int x, input int g);
    notes.push_back('{r, m, e, t, x, g});
  endtask : note

  task automatic wr_ild(input logic [2:0] sel, input logic [31:0] d);
    ild_d = d;
    ild_wr_a = sel[0];
    ild_wr_b = sel[1];
    ild_wr32 = sel[2];
    tick(1);
    {ild_wr32, ild_wr_b, ild_wr_a} = 3'h0;
  endtask : wr_ild

  task automatic wr_en(input logic [1:0] sel, input logic v);
    en_d_a = v;
    en_d_b = v;
    {en_wr_b, en_wr_a} = sel;
    tick(1);
    {en_wr_b, en_wr_a} = 2'h0;
  endtask : wr_en

  task automatic clr_flag(input logic [4:0] m);
    clr = m;
    tick(1);
    clr = 5'h00;
  endtask : clr_flag

  // Bounded wait: a flag that never rises shows up as one mismatch, not a hang
  task automatic wait_raw(input int b, input int lim);
    int i;
    for (i = 0; i < lim && raw[b] !== 1'h1; i++) tick(1);
    chk(raw[b], 32'h1);
  endtask : wait_raw

  // Outputs only move on the rising edge, so the falling edge sees them settled
  always @(negedge sys_clk) begin
    if (tpend) chk({trg_b, trg_a}, 32'h0);
    tpend = 1'h0;
    if ((raw & ~prev) != 5'h00) begin
      if (notes.size() == 0) chk(raw, prev);
      else begin
        nt = notes.pop_front();
        chk(raw & ~prev, nt.rise);
        chk(mskd, nt.mskd);
        chk({en_b, en_a}, nt.ena);
        chk({trg_b, trg_a}, nt.trg);
        if (nt.exp != 0) chk(cyc, nt.exp);
        if (nt.gap != 0) chk(cyc - last, nt.gap);
        tpend = 1'h1;
      end
      last = cyc;
    end
    prev = raw;
  end

  // One RTC tick needs 32768 pin periods of four clocks; the rest takes under two thousand
  initial begin
    repeat (136000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    tick(1);
    chk({cnt_b, cnt_a}, 32'hFFFF_FFFF);
    chk({en_b, en_a, raw, trg_b, trg_a}, 32'h0);
    tick(2);
    arst_n = 1'h1;
    tick(1);
    // 32-bit one-shot with trigger
    rnd = lfsr(rnd);
    ld = 32'h4 + rnd[3:0];
    mode_a = gpt_pkg::MODE_ONE_SHOT;
    msk = 5'h01;
    tr_a = 1'h1;
    wr_ild(3'h4, ld);
    tick(2);
    note(5'h01, 5'h01, 2'h0, 2'h1, cyc + ld + 2, 0);
    wr_en(2'h1, 1'h1);
    wait_raw(0, 40);
    tick(5);
    chk(raw, 5'h01);
    chk({cnt_b, cnt_a}, ld);
    clr_flag(5'h01);
    tick(1);
    chk({raw, mskd}, 32'h0);
    // 32-bit periodic, interrupt masked off, stalled for three cycles in the second period
    rnd = lfsr(rnd);
    ld = 32'h8 + rnd[2:0];
    mode_a = gpt_pkg::MODE_PERIODIC;
    msk = 5'h00;
    tr_a = 1'h0;
    wr_ild(3'h4, ld);
    tick(2);
    note(5'h01, 5'h00, 2'h1, 2'h0, cyc + ld + 2, 0);
    note(5'h01, 5'h00, 2'h1, 2'h0, 0, ld + 4);
    wr_en(2'h1, 1'h1);
    wait_raw(0, 40);
    clr_flag(5'h01);
    stl_a = 1'h1;
    tick(3);
    stl_a = 1'h0;
    wait_raw(0, 40);
    clr_flag(5'h01);
    wr_ild(3'h4, 32'h0000_0040);
    tick(2);
    chk({cnt_b, cnt_a}, 32'h0000_0040);
    tick(4);
    chk({cnt_b, cnt_a}, 32'h0000_003C);
    wr_en(2'h1, 1'h0);
    // Split mode, first half periodic with random prescale
    rnd = lfsr(rnd);
    ld = 32'h3 + rnd[2:0];
    psc_a = 8'h01 + rnd[9:8];
    cfg = gpt_pkg::CFG_SPLIT;
    msk = 5'h01;
    tr_a = 1'h1;
    wr_ild(3'h1, ld);
    tick(2);
    note(5'h01, 5'h01, 2'h1, 2'h1, 0, 0);
    note(5'h01, 5'h01, 2'h1, 2'h1, 0, (ld + 1) * (psc_a + 1));
    wr_en(2'h1, 1'h1);
    wait_raw(0, 200);
    clr_flag(5'h01);
    wait_raw(0, 200);
    clr_flag(5'h01);
    wr_en(2'h1, 1'h0);
    // Second half one-shot with its own prescale and trigger
    mode_b = gpt_pkg::MODE_ONE_SHOT;
    psc_b = {6'h00, rnd[17:16]};
    tr_b = 1'h1;
    msk = 5'h04;
    wr_ild(3'h2, ld);
    tick(2);
    note(5'h04, 5'h04, 2'h0, 2'h2, 0, 0);
    wr_en(2'h2, 1'h1);
    wait_raw(2, 200);
    tick(3);
    chk({en_b, cnt_b}, ld);
    clr_flag(5'h04);
    // Second half edge count: load 0xA, match 6, four edges then three extra pulses
    mode_b = gpt_pkg::MODE_EDGE_COUNT;
    mt_b = 16'h0006;
    msk = 5'h08;
    for (int s = 0; s < 3; s++) begin
      evsel_b = sels[s];
      wr_ild(3'h2, 32'h0000_000A);
      tick(2);
      note(5'h08, 5'h08, 2'h0, 2'h0, 0, 0);
      wr_en(2'h2, 1'h1);
      u_gpt_pin_model.pulse_b(s == 2 ? 5 : 7);
      tick(8);
      chk({en_b, cnt_b}, 32'h0000_000A);
      chk(raw, 5'h08);
      clr_flag(5'h08);
    end
    // RTC with both stall bits set and the override on
    msk = 5'h10;
    mt_a = 16'h0001;
    mt_b = 16'h0000;
    stl_a = 1'h1;
    stl_b = 1'h1;
    ovr = 1'h1;
    cfg = gpt_pkg::CFG_32_RTC;
    tick(3);
    chk({cnt_b, cnt_a}, 32'h0000_0001);
    note(5'h10, 5'h10, 2'h1, 2'h0, 0, 0);
    wr_en(2'h1, 1'h1);
    u_gpt_pin_model.run_a(32768);
    wait_raw(4, 100);
    tick(2);
    chk(rtc_irq, 32'h1);
    chk({cnt_b, cnt_a}, 32'h0000_0000);
    chk(en_a, 32'h1);
    clr_flag(5'h10);
    tick(2);
    chk({rtc_irq, raw, mskd}, 32'h0);
    end_sim();
  end
endmodule : gpt_timer_tb_top
`default_nettype wire
